// file: src/tsel_defs.svh
// Timing counts and reset values for the device select and off-line read block.
`ifndef TSEL_DEFS_SVH
`define TSEL_DEFS_SVH
`define TSEL_CLK_MHZ        250
`define TSEL_DEBOUNCE_US    1
`define TSEL_DEBOUNCE_CYC   (`TSEL_DEBOUNCE_US * `TSEL_CLK_MHZ)
`define TSEL_SEL_RESET      6'h00
`define TSEL_CHAR_BITS      7
`endif

// file: src/tsel_pkg.sv
// Types shared by the device select and off-line read block.
package tsel_pkg;
   typedef struct packed {
      logic typeIn;
      logic readerIn;
      logic auxIn;
      logic typeOut;
      logic punchOut;
      logic auxOut;
   } tsel_sel_s;
   typedef enum logic [1:0] {
      TSEL_IDLE,
      TSEL_ARMED,
      TSEL_READING
   } tsel_rd_e;
endpackage

// file: src/tsel_debounce.sv
// Debounces one momentary panel button and emits press and release pulses.
`timescale 1ns/1ps
`default_nettype none
`include "tsel_defs.svh"
module tsel_debounce
   import tsel_pkg::*;
#(
   parameter int STABLE_CYC = `TSEL_DEBOUNCE_CYC
)(
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rstSync_n,
   // Button
   input  wire logic rawBtn,
   output logic      level,
   output logic      pressPulse,
   output logic      releasePulse
);
   typedef struct packed {
      logic        sample;
      logic        stable;
      logic        prev;
      logic [15:0] count;
   } tsel_db_s;
   localparam logic [15:0] LIMIT = 16'(STABLE_CYC);
   tsel_db_s st_r;
   tsel_db_s st_nxt;
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.sample = rawBtn;
      st_nxt.prev = st_r.stable;
      if (st_r.sample == st_r.stable)
         st_nxt.count = 16'h0000;
      else if (st_r.count >= LIMIT)
      begin
         st_nxt.stable = st_r.sample;
         st_nxt.count = 16'h0000;
      end
      else
         st_nxt.count = st_r.count + 16'h0001;
   end
   always_ff @(posedge sys_clk or negedge rstSync_n)
   begin
      if (!rstSync_n)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end
   assign level        = st_r.stable;
   assign pressPulse   = st_r.stable & ~st_r.prev;
   assign releasePulse = ~st_r.stable & st_r.prev;
endmodule
`default_nettype wire

// file: src/tsel_top.sv
// Device selection and off-line read sequencing for the tape typewriter.
// Behaviour
// - Selection monitor lamp lights while any selection flip-flop is set.
// - Typewriter-to-computer button sets typewriter input select; lamp on.
// - Reader-to-computer button sets reader selection; lamp follows.
// - Aux-typewriter-to-computer button sets aux input select; lamp on.
// - Computer-to-typewriter button sets typewriter output select; lamp on.
// - Computer-to-punch button sets punch selection; lamp follows.
// - Computer-to-aux-typewriter button sets aux output select; lamp on.
// - Tape fault lights tape lamp; with reader selected or off-line, system halts.
// - Conditional stop reads past stop codes; otherwise stop code halts.
// - Conditional stop suppresses every turn-off of the off-line input flop.
// - Tape feed with punch off-line clears characters and cycles punch.
// - Typewriter off-line select ignores on-line advance and input select.
// - Off-line typewriter output held clear unless reader off-line too.
// - Punch off-line select detaches punch from on-line control.
// - Off-line reader advance comes from the off-line advance flop.
// - Releasing start-read with reader or typewriter off-line sets the off-line input flip-flop.
// - Holding start-read keeps off-line advance flip-flop cleared.
// - Stop-read button clears the off-line input flip-flop.
// - Single-character mode clears input flop on each read strobe.
// - Master reset clears every device selection flip-flop.
// - Off-line strobe fires at cam 1 with advance set, reader off-line.
`timescale 1ns/1ps
`default_nettype none
`include "tsel_defs.svh"
module tsel_top
   import tsel_pkg::*;
#(
   parameter int DEBOUNCE_CYC = `TSEL_DEBOUNCE_CYC,
   parameter int CHAR_BITS    = `TSEL_CHAR_BITS
)(
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 reset_n,
   // Momentary panel buttons, high while pressed
   input  wire logic                 btnTypeToCpu,
   input  wire logic                 btnReaderToCpu,
   input  wire logic                 btnAuxToCpu,
   input  wire logic                 btnCpuToType,
   input  wire logic                 btnCpuToPunch,
   input  wire logic                 btnCpuToAux,
   input  wire logic                 btnMasterReset,
   input  wire logic                 btnStartRead,
   input  wire logic                 btnStopRead,
   input  wire logic                 btnTapeFeed,
   // Latching panel switches
   input  wire logic                 condStop,
   input  wire logic                 singleChar,
   input  wire logic                 typeOffline,
   input  wire logic                 punchOffline,
   input  wire logic                 readerOffline,
   // Deselect pulses from the computer
   input  wire tsel_sel_s            deselect,
   // Computer side
   input  wire logic                 cpuAdvance,
   input  wire logic                 cpuTypeOut,
   input  wire logic                 cpuPunchCycle,
   // Reader and typewriter side
   input  wire logic                 readerCam1,
   input  wire logic                 tapeFault,
   input  wire logic                 stopCode,
   input  wire logic [CHAR_BITS-1:0] brushChar,
   input  wire logic                 typeKeyStrobe,
   // Indicators
   output tsel_sel_s                 selLamps,
   output logic                      selMonitorLamp,
   output logic                      tapeMonitorLamp,
   output logic                      condStopLamp,
   // Device control
   output logic                      systemHalt,
   output logic                      readerAdvance,
   output logic                      typeAdvance,
   output logic                      offReadStrobe,
   output logic                      offInputOn,
   output logic                      offTypeOut,
   output logic                      punchCycle,
   output logic [CHAR_BITS-1:0]      offChar
);
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      tsel_sel_s            sel;
      logic                 offInput;
      logic                 offAdvance;
      logic                 offTypeOut;
      logic                 strobe;
      logic                 punch;
      logic                 cam1Prev;
      logic [CHAR_BITS-1:0] chr;
   } tsel_state_s;
   logic [1:0]  rstPipe_r;
   logic        rstSync_n;
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         rstPipe_r <= 2'h0;
      else
         rstPipe_r <= {rstPipe_r[0], 1'b1};
   end
   assign rstSync_n = rstPipe_r[1];
   ////////////////////////////////////////////////////////////////////////
   localparam int NBTN = 10;
   logic [NBTN-1:0] rawBtns;
   logic [NBTN-1:0] btnLevel;
   logic [NBTN-1:0] btnPress;
   logic [NBTN-1:0] btnRelease;
   assign rawBtns = {btnTapeFeed, btnStopRead, btnStartRead, btnMasterReset,
                     btnCpuToAux, btnCpuToPunch, btnCpuToType, btnAuxToCpu,
                     btnReaderToCpu, btnTypeToCpu};
   for (genvar i = 0; i < NBTN; i++)
   begin : gBtn
      tsel_debounce #(
         .STABLE_CYC   (DEBOUNCE_CYC)
      ) uDb (
         .sys_clk      (sys_clk),
         .rstSync_n    (rstSync_n),
         .rawBtn       (rawBtns[i]),
         .level        (btnLevel[i]),
         .pressPulse   (btnPress[i]),
         .releasePulse (btnRelease[i])
      );
   end
   ////////////////////////////////////////////////////////////////////////
   tsel_state_s st_r;
   tsel_state_s st_nxt;
   logic        faultHalt;
   logic        cam1Rise;
   logic        turnOff;
   always_comb
   begin
      st_nxt = st_r;
      cam1Rise = readerCam1 & ~st_r.cam1Prev;
      st_nxt.cam1Prev = readerCam1;
      faultHalt = tapeFault & (st_r.sel.readerIn | readerOffline);
      if (btnPress[0])
         st_nxt.sel.typeIn = 1'b1;
      if (btnPress[1])
         st_nxt.sel.readerIn = 1'b1;
      if (btnPress[2])
         st_nxt.sel.auxIn = 1'b1;
      if (btnPress[3])
         st_nxt.sel.typeOut = 1'b1;
      if (btnPress[4])
         st_nxt.sel.punchOut = 1'b1;
      if (btnPress[5])
         st_nxt.sel.auxOut = 1'b1;
      st_nxt.sel = st_nxt.sel & ~deselect;
      if (btnPress[6])
         st_nxt.sel = `TSEL_SEL_RESET;
      st_nxt.strobe = cam1Rise & st_r.offAdvance & readerOffline & ~faultHalt;
      // Advance follows the input flop; strobe ends each advance cycle.
      if (st_r.strobe)
         st_nxt.offAdvance = 1'b0;
      else if (st_r.offInput & ~faultHalt)
         st_nxt.offAdvance = 1'b1;
      if (btnLevel[7])
         st_nxt.offAdvance = 1'b0;
      // Turn-off sources: stop button, stop code, single character, fault.
      // stop read clears
      turnOff = btnPress[8];
      turnOff = turnOff | (st_r.strobe & stopCode);
      turnOff = turnOff | (singleChar & (st_r.strobe | typeKeyStrobe));
      turnOff = turnOff | faultHalt;
      if (condStop)
         turnOff = 1'b0;
      if (btnRelease[7] & (readerOffline | typeOffline))
         st_nxt.offInput = 1'b1;
      else if (turnOff)
         st_nxt.offInput = 1'b0;
      // Characters are captured from the brushes on each strobe unless a punch off-line tape feed clears them.
      if (st_r.strobe)
         st_nxt.chr = brushChar;
      st_nxt.punch = 1'b0;
      if (btnLevel[9] & punchOffline)
      begin
         st_nxt.chr = '0;
         st_nxt.punch = 1'b1;
      end
      else if (punchOffline)
         st_nxt.punch = st_r.strobe;
      if (typeOffline & ~readerOffline)
         st_nxt.offTypeOut = 1'b0;
      else
         st_nxt.offTypeOut = typeOffline & st_r.strobe;
   end
   always_ff @(posedge sys_clk or negedge rstSync_n)
   begin
      if (!rstSync_n)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end
   ////////////////////////////////////////////////////////////////////////
   // Off-line control drives the device, otherwise the computer's request
   // gated by the device's selection.
   function automatic logic pickSource(input logic offline,
                                       input logic offVal,
                                       input logic onReq,
                                       input logic onSel);
      return offline ? offVal : (onReq & onSel);
   endfunction
   assign selLamps = st_r.sel;
   assign selMonitorLamp  = |st_r.sel;
   assign tapeMonitorLamp = tapeFault;
   assign systemHalt      = faultHalt;
   assign condStopLamp    = condStop;
   assign readerAdvance   = pickSource(readerOffline, st_r.offAdvance,
                                       cpuAdvance, st_r.sel.readerIn);
   assign typeAdvance     = pickSource(typeOffline, st_r.offAdvance,
                                       cpuAdvance, st_r.sel.typeIn);
   assign punchCycle      = pickSource(punchOffline, st_r.punch,
                                       cpuPunchCycle, st_r.sel.punchOut);
   assign offTypeOut      = pickSource(typeOffline, st_r.offTypeOut,
                                       cpuTypeOut, st_r.sel.typeOut);
   assign offReadStrobe   = st_r.strobe;
   assign offInputOn      = st_r.offInput;
   assign offChar         = st_r.chr;
endmodule
`default_nettype wire

// file: verification/tsel_top_props.sv
// Concurrent checks on the ports of the device select block.
`timescale 1ns/1ps
`default_nettype none
module tsel_top_props
   import tsel_pkg::*;
#(
   parameter int CHAR_BITS = 7
)(
   // Clock, reset and design inputs
   input wire logic                 sys_clk,
   input wire logic                 reset_n,
   input wire logic                 btnMasterReset,
   input wire logic                 btnStartRead,
   input wire logic                 btnTapeFeed,
   input wire logic                 condStop,
   input wire logic                 singleChar,
   input wire logic                 punchOffline,
   input wire logic                 readerOffline,
   input wire tsel_sel_s            deselect,
   input wire logic                 tapeFault,
   // Design outputs
   input wire tsel_sel_s            selLamps,
   input wire logic                 selMonitorLamp,
   input wire logic                 systemHalt,
   input wire logic                 readerAdvance,
   input wire logic                 offReadStrobe,
   input wire logic                 offInputOn,
   input wire logic                 punchCycle,
   input wire logic [CHAR_BITS-1:0] offChar
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   sequence startHeld;
      (readerOffline && btnStartRead) [*8];
   endsequence
   sequence feedHeld;
      (punchOffline && btnTapeFeed) [*8];
   endsequence
   AST_SEL_MONITOR: assert property (selMonitorLamp == (|selLamps))
      else $error("monitor lamp differs from selections");
   AST_HALT: assert property (
      tapeFault && (selLamps.readerIn || readerOffline) |-> systemHalt)
      else $error("tape fault did not halt");
   AST_STROBE: assert property (
      offReadStrobe |-> $past(readerOffline) && !$past(offReadStrobe))
      else $error("read strobe without off-line reader");
   AST_COND_HOLD: assert property (
      $fell(offInputOn) |-> !$past(condStop))
      else $error("input turned off under conditional stop");
   AST_SINGLE: assert property (
      offReadStrobe && singleChar && !condStop |-> ##[1:2] !offInputOn)
      else $error("single character did not stop input");
   AST_START_HELD: assert property (startHeld |-> !readerAdvance)
      else $error("advance set while start held");
   AST_SEL_DROP: assert property (
      |($past(selLamps) & ~selLamps) |-> btnMasterReset || |$past(deselect))
      else $error("selection dropped without cause");
   AST_FEED: assert property (
      feedHeld |-> offChar == 0 && punchCycle)
      else $error("tape feed did not blank and cycle");
endmodule
bind tsel_top tsel_top_props #(.CHAR_BITS(CHAR_BITS)) u_props (
   .sys_clk(sys_clk), .reset_n(reset_n), .btnMasterReset(btnMasterReset),
   .btnStartRead(btnStartRead), .btnTapeFeed(btnTapeFeed),
   .condStop(condStop), .singleChar(singleChar), .punchOffline(punchOffline),
   .readerOffline(readerOffline), .deselect(deselect), .tapeFault(tapeFault),
   .selLamps(selLamps), .selMonitorLamp(selMonitorLamp),
   .systemHalt(systemHalt), .readerAdvance(readerAdvance),
   .offReadStrobe(offReadStrobe), .offInputOn(offInputOn),
   .punchCycle(punchCycle), .offChar(offChar));
`default_nettype wire

// file: verification/tsel_reader_model.sv
// Behavioural paper tape reader: cam timing, brush reading and stop codes.
`timescale 1ns/1ps
`default_nettype none
module tsel_reader_model
(
   // Clock and control
   input  wire logic  sys_clk,
   input  wire logic  stopEn,
   // Reader outputs
   output logic       readerCam1,
   output logic       stopCode,
   output logic [6:0] brushChar
);
   logic [3:0] phase_r = 4'h0;
   logic [6:0] char_r = 7'h11;
   // Tape moves only while the cam is low, so brushes are stable at cam 1.
   always_ff @(posedge sys_clk)
   begin
      phase_r <= phase_r + 4'h1;
      if (phase_r == 4'hf)
         char_r <= char_r + 7'h05;
   end
   assign readerCam1 = phase_r[3] & phase_r[2];
   assign brushChar = char_r;
   assign stopCode = stopEn & (char_r[1:0] == 2'h3);
endmodule
`default_nettype wire

// file: verification/tsel_top_tb_top.sv
// Self-checking bench for the device select and off-line read block.
`timescale 1ns/1ps
`default_nettype none
module tsel_top_tb_top
   import tsel_pkg::*;
();
   logic       sys_clk = 1'b0;
   logic       reset_n = 1'b0;
   logic [9:0] btn = 10'h000;
   logic [4:0] sw = 5'h00;
   logic [2:0] cpu = 3'h0;
   logic       tapeFault = 1'b0;
   logic       stopEn = 1'b0;
   tsel_sel_s  deselect = 6'h00;
   tsel_sel_s  selLamps;
   logic       monLamp, tapeLamp, halt, rdAdv, tyAdv, strobe, inOn, tyOut;
   logic       punch, cam, stopCode, condLamp;
   logic       keyStb = 1'b0;
   logic [6:0] brushChar, offChar, seen;
   int         fails = 0;
   int         total_checks = 0;

   always #2 sys_clk = ~sys_clk;

   tsel_top #(.DEBOUNCE_CYC(2)) dut (
      .sys_clk(sys_clk), .reset_n(reset_n),
      .btnTypeToCpu(btn[0]), .btnReaderToCpu(btn[1]), .btnAuxToCpu(btn[2]),
      .btnCpuToType(btn[3]), .btnCpuToPunch(btn[4]), .btnCpuToAux(btn[5]),
      .btnMasterReset(btn[6]), .btnStartRead(btn[7]), .btnStopRead(btn[8]),
      .btnTapeFeed(btn[9]), .condStop(sw[4]), .singleChar(sw[3]),
      .typeOffline(sw[2]), .punchOffline(sw[1]), .readerOffline(sw[0]),
      .deselect(deselect), .cpuAdvance(cpu[2]), .cpuTypeOut(cpu[1]),
      .cpuPunchCycle(cpu[0]), .readerCam1(cam), .tapeFault(tapeFault),
      .stopCode(stopCode), .brushChar(brushChar), .typeKeyStrobe(keyStb),
      .selLamps(selLamps), .selMonitorLamp(monLamp), .tapeMonitorLamp(tapeLamp),
      .condStopLamp(condLamp), .systemHalt(halt), .readerAdvance(rdAdv),
      .typeAdvance(tyAdv), .offReadStrobe(strobe), .offInputOn(inOn),
      .offTypeOut(tyOut), .punchCycle(punch), .offChar(offChar));

   tsel_reader_model reader (.sys_clk(sys_clk), .stopEn(stopEn),
      .readerCam1(cam), .stopCode(stopCode), .brushChar(brushChar));

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // The release wait is short for start-read so the input flop is seen
   // before any read cycle can end it.
   task automatic press(input int i, input int n);
      btn[i] = 1'b1;
      cyc(12);
      btn[i] = 1'b0;
      cyc(n);
   endtask
   task automatic waitStrobe();
      int k;
      for (k = 0; k < 100 && strobe !== 1'b1; k++)
         cyc(1);
      if (k == 100)
      begin
         fails++;
         end_of_test();
      end
      seen = brushChar;
      cyc(1);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      cyc(16);
      reset_n = 1'b1;
      cyc(8);
      for (int i = 0; i < 6; i++)
      begin
         press(i, 12);
         chk(selLamps, 6'h3f & (6'h3f << (5 - i)));
         chk(monLamp, 1'b1);
      end
      deselect = 6'h08;
      cyc(2);
      deselect = 6'h00;
      cyc(2);
      chk(selLamps, 6'h37);
      tapeFault = 1'b1;
      cyc(1);
      chk({tapeLamp, halt}, 2'h3);
      tapeFault = 1'b0;
      cpu = 3'h7;
      cyc(2);
      chk({rdAdv, punch}, 2'h3);
      sw = 5'h06;
      cyc(2);
      chk({tyAdv, tyOut, punch}, 3'h0);
      sw = 5'h07;
      cyc(2);
      chk(rdAdv, 1'b0);
      cpu = 3'h0;
      press(6, 12);
      chk({selLamps, monLamp}, 7'h00);
      tapeFault = 1'b1;
      cyc(1);
      chk(halt, 1'b1);
      tapeFault = 1'b0;
      press(7, 7);
      chk(inOn, 1'b1);
      repeat (3)
      begin
         waitStrobe();
         chk(offChar, seen);
      end
      press(8, 12);
      chk(inOn, 1'b0);
      sw = 5'h0f;
      press(7, 7);
      waitStrobe();
      cyc(2);
      chk(inOn, 1'b0);
      sw = 5'h0e;
      press(7, 7);
      chk(inOn, 1'b1);
      keyStb = 1'b1;
      cyc(1);
      keyStb = 1'b0;
      cyc(2);
      chk(inOn, 1'b0);
      sw = 5'h1f;
      stopEn = 1'b1;
      press(7, 7);
      repeat (5) waitStrobe();
      press(8, 12);
      chk({inOn, condLamp}, 2'h3);
      sw = 5'h07;
      for (int k = 0; k < 5 && inOn === 1'b1; k++)
         waitStrobe();
      cyc(2);
      chk(inOn, 1'b0);
      stopEn = 1'b0;
      btn[9] = 1'b1;
      cyc(12);
      chk({punch, offChar}, 8'h80);
      btn[9] = 1'b0;
      cyc(20);
      end_of_test();
   end
endmodule
`default_nettype wire
